// [common/uepc_pkg.sv]
package uepc_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_LAST_ENDPOINT  = 8'h30;
  localparam logic [7:0] OFF_SPECIAL_MASK   = 8'h34;
  localparam logic [7:0] OFF_OTG_FLAG_MASK  = 8'h38;
  localparam logic [7:0] OFF_POWER_SIGNAL   = 8'h3C;
  localparam logic [7:0] OFF_PHY_CONTROL    = 8'h40;
  localparam logic [7:0] OFF_DEVICE_ADDRESS = 8'h44;
  localparam logic [7:0] OFF_IRQ_STATUS     = 8'h48;
  localparam logic [7:0] OFF_IRQ_MASK       = 8'h4C;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int EP_VALID_BIT      = 4;
  localparam int EP_TAG_BIT        = 4;
  localparam int PWR_VALID_BIT     = 8;
  localparam int PHY_PD_DIS_BIT    = 18;
  localparam int PHY_SE0_CAUSE_BIT = 13;
  localparam int PHY_K_CAUSE_BIT   = 12;
  localparam int PHY_FILT_LSB      = 8;
  localparam int PHY_FILT_MSB      = 11;
  localparam int PHY_HW_RESUME_BIT = 7;
  localparam int PHY_CONF_LSB      = 4;
  localparam int PHY_CONF_MSB      = 6;
  localparam int IRQ_TOKEN_BIT     = 0;
  localparam int IRQ_LINE_BIT      = 1;
  localparam int IRQ_RESUME_BIT    = 2;
  localparam int IRQ_WIDTH         = 3;

  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
  localparam logic [31:0] WMASK_SPECIAL   = 32'h0000_FFFF;
  localparam logic [31:0] WMASK_POWER     = 32'h0000_01FF;
  localparam logic [31:0] WMASK_PHY       = 32'h0004_3FF0;
  localparam logic [31:0] WMASK_DEVADDR   = 32'h0000_007F;
  localparam logic [31:0] WMASK_IRQ       = 32'h0000_0007;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  // UTMI line states
  localparam logic [1:0] LS_SE0 = 2'b00;
  localparam logic [1:0] LS_K   = 2'b10;

  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
    logic [3:0] endpoint;
  } uepc_token_t;

  // Special flag on top, so the port reads as endpoint | 0x10
  typedef struct packed {
    logic       special;
    logic [3:0] endpoint;
  } uepc_rx_ep_t;

endpackage : uepc_pkg

// [dv/uepc_phy_model.sv]
`timescale 1ns/1ps
// ****************************************
// PHY and line model
// ****************************************
module uepc_phy_model (
  // Clock
  input  wire logic       sys_clk,
  // Bench requests
  input  wire logic [1:0] req_state,
  input  wire logic       req_susp,
  // UTMI side
  output logic [1:0]      phy_linestate,
  output logic            phy_suspended
);
  // One clock of lag, as a synchronised PHY output would show
  always_ff @(posedge sys_clk)
  begin
    phy_linestate <= req_state;
    phy_suspended <= req_susp;
  end
endmodule : uepc_phy_model

// [dv/uepc_top_bench.sv]
`timescale 1ns/1ps
module uepc_top_bench;
  // ****************************************
  // Signals
  // ****************************************
  logic                  sys_clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                  s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]            s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]           s_axi_wdata = 32'h0;
  logic [3:0]            s_axi_wstrb = 4'hF;
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]            s_axi_bresp, s_axi_rresp, resp;
  logic [31:0]           s_axi_rdata, rd;
  uepc_pkg::uepc_token_t token_in = '0;
  uepc_pkg::uepc_rx_ep_t rx_endpoint;
  logic                  rx_endpoint_valid, suspend_resume, irq, phy_suspended, seen;
  logic                  phy_port_a_pulldown_dis, phy_port_b_pulldown_dis, req_susp = 1'b0;
  logic [1:0]            phy_linestate, linestate_filt, req_state = 2'b01;
  logic [2:0]            phy_config_pins;
  int                    failures = 0, n_compared = 0;

  always #20 sys_clk = ~sys_clk;

  uepc_top #(.ADDR_W(8)) dut_u (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .token_in, .rx_endpoint, .rx_endpoint_valid, .phy_linestate,
    .phy_suspended, .linestate_filt, .suspend_resume, .phy_config_pins,
    .phy_port_a_pulldown_dis, .phy_port_b_pulldown_dis, .irq);

  uepc_phy_model phy_u (.sys_clk, .req_state, .req_susp, .phy_linestate, .phy_suspended);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_up(input string what);
    failures++;
    $display("MISMATCH %s expected handshake seen timeout", what);
    tally_and_finish();
  endtask : give_up

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (i == 50) give_up("write response");
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    int i;
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (i == 50) give_up("read data");
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    rdr(a);
    chk(what, exp, rd);
  endtask : rchk

  // Token stands one clock; returns where the answer is standing
  task automatic tok(input logic [6:0] a, input logic [3:0] e);
    @(posedge sys_clk);
    token_in <= '{valid: 1'b1, addr: a, endpoint: e};
    @(posedge sys_clk);
    token_in.valid <= 1'b0;
    @(posedge sys_clk);
  endtask : tok

  task automatic line_to(input logic [1:0] s);
    int i;
    seen = 1'b0;
    @(posedge sys_clk);
    req_state <= s;
    for (i = 0; i < 10; i++)
    begin
      @(posedge sys_clk);
      if (suspend_resume === 1'b1) seen = 1'b1;
    end
  endtask : line_to

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rchk(8'h30, 32'h0, "last_endpoint");
    rchk(8'h34, 32'h0, "special_mask");
    rchk(8'h3C, 32'h0, "power_signalling");
    rchk(8'h40, 32'h0, "phy_control");
    chk("linestate_filt", 32'h1, 32'(linestate_filt));
    rdr(8'h50);
    chk("unmapped_resp", 32'(uepc_pkg::RESP_SLVERR), 32'(resp));
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    wr(8'h30, 32'hFFFF_FFFF);
    rchk(8'h30, 32'h0, "last_endpoint_ro");
    wr(8'h34, 32'hFFFF_FFFF);
    rchk(8'h34, 32'h0000_FFFF, "special_mask");
    wr(8'h38, 32'hA5A5_5A5A);
    rchk(8'h38, 32'hA5A5_5A5A, "otg_flag_mask");
    wr(8'h3C, 32'hFFFF_FFFF);
    rchk(8'h3C, 32'h0000_01FF, "power_signalling");
    wr(8'h40, 32'hFFFF_FFFF);
    rchk(8'h40, 32'h0004_3FF0, "phy_control");
    chk("config_pins", 32'h7, 32'(phy_config_pins));
    chk("pulldown_a", 32'h1, 32'(phy_port_a_pulldown_dis));
    chk("pulldown_b", 32'h1, 32'(phy_port_b_pulldown_dis));
    wr(8'h40, 32'h0000_0050);
    chk("config_pins", 32'h5, 32'(phy_config_pins));
    chk("pulldown_a", 32'h0, 32'(phy_port_a_pulldown_dis));
    $display("test registers done");
  endtask : t_regs

  task automatic t_token();
    wr(8'h44, 32'h0000_0015);
    wr(8'h34, 32'h0000_0200);
    tok(7'h16, 4'h3);
    chk("rx_valid_foreign", 32'h0, 32'(rx_endpoint_valid));
    chk("rx_endpoint_foreign", 32'h0, 32'(rx_endpoint));
    rchk(8'h30, 32'h0, "last_endpoint_foreign");
    tok(7'h15, 4'h9);
    chk("rx_valid_own", 32'h1, 32'(rx_endpoint_valid));
    chk("rx_endpoint_special", 32'h19, 32'(rx_endpoint));
    rchk(8'h30, 32'h19, "last_endpoint");
    tok(7'h15, 4'hF);
    chk("rx_endpoint_plain", 32'h0F, 32'(rx_endpoint));
    rchk(8'h30, 32'h1F, "last_endpoint");
    $display("test token done");
  endtask : t_token

  task automatic t_filter(input int n);
    int i, cnt;
    wr(8'h40, 32'(n) << 8);
    if (n > 0)
    begin
      req_state <= uepc_pkg::LS_K;
      repeat ((1 << n) - 1) @(posedge sys_clk);
      req_state <= 2'b01;
    end
    cnt = 0;
    repeat (12)
    begin
      @(posedge sys_clk);
      if (linestate_filt !== 2'b01) cnt++;
    end
    chk("filt_glitch", 32'h0, 32'(cnt));
    req_state <= uepc_pkg::LS_K;
    cnt = 0;
    for (i = 0; i < 40 && linestate_filt !== uepc_pkg::LS_K; i++)
    begin
      @(posedge sys_clk);
      if (phy_linestate === uepc_pkg::LS_K && linestate_filt !== uepc_pkg::LS_K) cnt++;
    end
    chk("filt_delay", 32'(1 << n), 32'(cnt));
    line_to(2'b01);
    $display("test filter done");
  endtask : t_filter

  task automatic t_resume();
    wr(8'h40, 32'h0000_0080);
    req_susp <= 1'b1;
    line_to(uepc_pkg::LS_SE0);
    chk("resume_se0_pulse", 32'h1, 32'(seen));
    rchk(8'h40, 32'h0000_2080, "se0_cause");
    line_to(2'b01);
    rchk(8'h40, 32'h0000_2080, "se0_cause_sticky");
    wr(8'h40, 32'h0000_0080);
    rchk(8'h40, 32'h0000_0080, "se0_cause_clear");
    line_to(uepc_pkg::LS_K);
    rchk(8'h40, 32'h0000_1080, "k_cause");
    wr(8'h40, 32'h0000_0000);
    rchk(8'h40, 32'h0000_0000, "k_cause_clear");
    line_to(2'b01);
    line_to(uepc_pkg::LS_SE0);
    chk("polled_no_pulse", 32'h0, 32'(seen));
    chk("polled_filt", 32'h0, 32'(linestate_filt));
    rchk(8'h40, 32'h0, "polled_no_cause");
    $display("test resume done");
  endtask : t_resume

  task automatic t_irq();
    rchk(8'h48, 32'h7, "irq_status");
    chk("irq_masked", 32'h0, 32'(irq));
    wr(8'h4C, 32'h4);
    @(posedge sys_clk);
    chk("irq_unmasked", 32'h1, 32'(irq));
    wr(8'h48, 32'h4);
    @(posedge sys_clk);
    chk("irq_cleared", 32'h0, 32'(irq));
    rchk(8'h48, 32'h3, "irq_status_w1c");
    $display("test interrupt done");
  endtask : t_irq

  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_token();
    t_filter(0);
    t_filter(2);
    t_resume();
    t_irq();
    tally_and_finish();
  end
endmodule : uepc_top_bench

// [logic/uepc_top.sv]
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// Function
// RULE_01: Store endpoint of latest received token
// RULE_02: Bit 4 flags stored endpoint valid
// RULE_03: Masked endpoints tagged with 0x10 on receive
// RULE_04: SE0 auto-resume sets sticky bit 13
// RULE_05: K auto-resume sets sticky bit 12
// RULE_06: Line-state filter delay two power field
// RULE_07: Bit 7 selects hardware or polled resume
// RULE_08: Bits 6:4 drive PHY config pins
// RULE_09: Bit 18 disables port pulldowns
// RULE_10: Pass only tokens matching device address
// RULE_11: Forward line state only after stable
// RULE_12: Reserved bits read zero, ignore writes
module uepc_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Decoded token from packet engine
  input  wire uepc_pkg::uepc_token_t token_in,
  // Receive port endpoint
  output uepc_pkg::uepc_rx_ep_t   rx_endpoint,
  output logic                    rx_endpoint_valid,
  // PHY
  input  wire logic [1:0]         phy_linestate,
  input  wire logic               phy_suspended,
  output logic [1:0]              linestate_filt,
  output logic                    suspend_resume,
  output logic [2:0]              phy_config_pins,
  output logic                    phy_port_a_pulldown_dis,
  output logic                    phy_port_b_pulldown_dis,
  // Interrupt
  output logic                    irq
);

  // ****************************************
  // Register state
  // ****************************************
  logic [3:0]  last_ep,   next_last_ep;
  logic        ep_valid,  next_ep_valid;
  logic [15:0] special_mask, next_special_mask;
  logic [31:0] otg_flag_mask, next_otg_flag_mask;
  logic [8:0]  power_signalling, next_power_signalling;
  logic [31:0] phy_control, next_phy_control;
  logic [6:0]  device_address, next_device_address;
  logic [2:0]  irq_status, next_irq_status;
  logic [2:0]  irq_mask, next_irq_mask;

  // ****************************************
  // AXI4-Lite handshake state
  // ****************************************
  logic              aw_held, next_aw_held;
  logic              w_held,  next_w_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0]       w_data,  next_w_data;
  logic [3:0]        w_strb,  next_w_strb;
  logic              bvalid,  next_bvalid;
  logic [1:0]        bresp,   next_bresp;
  logic              rvalid,  next_rvalid;
  logic [1:0]        rresp,   next_rresp;
  logic [31:0]       rdata,   next_rdata;

  logic wr_fire;
  logic rd_fire;
  logic [7:0] wr_off;
  logic [7:0] rd_off;
  logic [31:0] wr_bits;

  // Accept each channel once; hold until response accepted
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rresp   = rresp;
  assign s_axi_rdata   = rdata;

  logic              aw_now;
  logic              w_now;
  logic [ADDR_W-1:0] eff_awaddr;
  logic [31:0]       eff_wdata;
  logic [3:0]        eff_wstrb;

  always_comb
  begin
    aw_now     = aw_held || (s_axi_awvalid && s_axi_awready);
    w_now      = w_held || (s_axi_wvalid && s_axi_wready);
    eff_awaddr = aw_held ? aw_addr : s_axi_awaddr;
    eff_wdata  = w_held ? w_data : s_axi_wdata;
    eff_wstrb  = w_held ? w_strb : s_axi_wstrb;
    wr_fire    = aw_now && w_now && !bvalid;
    rd_fire    = s_axi_arvalid && s_axi_arready;
    wr_off     = {eff_awaddr[7:2], 2'b00};
    rd_off     = {s_axi_araddr[7:2], 2'b00};
    wr_bits    = {{8{eff_wstrb[3]}}, {8{eff_wstrb[2]}}, {8{eff_wstrb[1]}}, {8{eff_wstrb[0]}}};
  end

  function automatic logic mapped(input logic [7:0] off);
    mapped = (off == uepc_pkg::OFF_LAST_ENDPOINT) || (off == uepc_pkg::OFF_SPECIAL_MASK)
          || (off == uepc_pkg::OFF_OTG_FLAG_MASK) || (off == uepc_pkg::OFF_POWER_SIGNAL)
          || (off == uepc_pkg::OFF_PHY_CONTROL) || (off == uepc_pkg::OFF_DEVICE_ADDRESS)
          || (off == uepc_pkg::OFF_IRQ_STATUS) || (off == uepc_pkg::OFF_IRQ_MASK);
  endfunction : mapped

  // Merge write data under byte strobes and writable mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] be, input logic [31:0] wm);
    merge = (old & ~(be & wm)) | (nw & be & wm);
  endfunction : merge

  // ****************************************
  // Line-state filter
  // ****************************************
  logic [1:0]  ls_cand,  next_ls_cand;
  logic [15:0] ls_count, next_ls_count;
  logic [1:0]  ls_filt,  next_ls_filt;
  logic [15:0] ls_limit;
  logic        ls_change;

  always_comb
  begin
    ls_limit      = 16'h0001 << phy_control[uepc_pkg::PHY_FILT_MSB:uepc_pkg::PHY_FILT_LSB]; // [RULE_06]
    next_ls_cand  = ls_cand;
    next_ls_count = ls_count;
    next_ls_filt  = ls_filt;
    ls_change     = 1'b0;
    if (phy_linestate != ls_cand)
    begin
      // Any glitch restarts the stability count
      next_ls_cand  = phy_linestate; // [RULE_11]
      next_ls_count = 16'h0001;
      // Shortest delay: the first sample already fills the window
      if (ls_limit == 16'h0001 && phy_linestate != ls_filt)
      begin
        next_ls_filt = phy_linestate; // [RULE_06]
        ls_change    = 1'b1;
      end
    end
    else if (ls_cand != ls_filt)
    begin
      if (ls_count >= ls_limit - 16'h0001)
      begin
        next_ls_filt = ls_cand; // [RULE_06] [RULE_11]
        ls_change    = 1'b1;
      end
      else
      begin
        next_ls_count = ls_count + 16'h0001;
      end
    end
  end

  assign linestate_filt = ls_filt;

  // ****************************************
  // Resume detection
  // ****************************************
  logic hw_resume;
  logic resume_se0;
  logic resume_k;
  logic resume_q, next_resume_q;

  always_comb
  begin
    hw_resume     = phy_control[uepc_pkg::PHY_HW_RESUME_BIT]; // [RULE_07]
    resume_se0    = hw_resume && phy_suspended && ls_change && next_ls_filt == uepc_pkg::LS_SE0;
    resume_k      = hw_resume && phy_suspended && ls_change && next_ls_filt == uepc_pkg::LS_K;
    next_resume_q = resume_se0 || resume_k;
  end

  assign suspend_resume = resume_q; // [RULE_07]

  // ****************************************
  // Token capture
  // ****************************************
  logic tok_ok;

  always_comb
  begin
    tok_ok = token_in.valid && (token_in.addr == device_address); // [RULE_10]
  end

  // ****************************************
  // Register next-state
  // ****************************************
  always_comb
  begin
    next_last_ep          = last_ep;
    next_ep_valid         = ep_valid;
    next_special_mask     = special_mask;
    next_otg_flag_mask    = otg_flag_mask;
    next_power_signalling = power_signalling;
    next_phy_control      = phy_control;
    next_device_address   = device_address;
    next_irq_status       = irq_status;
    next_irq_mask         = irq_mask;
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;

    if (s_axi_awvalid && s_axi_awready && !(w_now))
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready && !(aw_now))
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end

    // Software writes; reserved bits masked off [RULE_12]
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(wr_off) ? uepc_pkg::RESP_OKAY : uepc_pkg::RESP_SLVERR;
      unique case (wr_off)
        uepc_pkg::OFF_SPECIAL_MASK:
          next_special_mask = 16'(merge({16'h0000, special_mask}, eff_wdata, wr_bits,
                                        uepc_pkg::WMASK_SPECIAL)); // [RULE_03]
        uepc_pkg::OFF_OTG_FLAG_MASK:
          next_otg_flag_mask = merge(otg_flag_mask, eff_wdata, wr_bits, 32'hFFFF_FFFF);
        uepc_pkg::OFF_POWER_SIGNAL:
          next_power_signalling = 9'(merge({23'h0, power_signalling}, eff_wdata, wr_bits,
                                           uepc_pkg::WMASK_POWER));
        uepc_pkg::OFF_PHY_CONTROL:
          next_phy_control = merge(phy_control, eff_wdata, wr_bits, uepc_pkg::WMASK_PHY);
        uepc_pkg::OFF_DEVICE_ADDRESS:
          next_device_address = 7'(merge({25'h0, device_address}, eff_wdata, wr_bits,
                                         uepc_pkg::WMASK_DEVADDR));
        uepc_pkg::OFF_IRQ_STATUS:
          next_irq_status = irq_status & ~(eff_wdata[2:0] & wr_bits[2:0]);
        uepc_pkg::OFF_IRQ_MASK:
          next_irq_mask = 3'(merge({29'h0, irq_mask}, eff_wdata, wr_bits, uepc_pkg::WMASK_IRQ));
        default:
          next_bvalid = 1'b1;
      endcase
    end
    if (bvalid && s_axi_bready)
      next_bvalid = 1'b0;

    // Hardware events win over a same-cycle software clear
    if (tok_ok)
    begin
      next_last_ep  = token_in.endpoint; // [RULE_01]
      next_ep_valid = 1'b1; // [RULE_02]
      next_irq_status[uepc_pkg::IRQ_TOKEN_BIT] = 1'b1;
    end
    if (ls_change)
      next_irq_status[uepc_pkg::IRQ_LINE_BIT] = 1'b1;
    if (resume_se0)
    begin
      next_phy_control[uepc_pkg::PHY_SE0_CAUSE_BIT] = 1'b1; // [RULE_04]
      next_irq_status[uepc_pkg::IRQ_RESUME_BIT] = 1'b1;
    end
    if (resume_k)
    begin
      next_phy_control[uepc_pkg::PHY_K_CAUSE_BIT] = 1'b1; // [RULE_05]
      next_irq_status[uepc_pkg::IRQ_RESUME_BIT] = 1'b1;
    end

    if (rd_fire)
    begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(rd_off) ? uepc_pkg::RESP_OKAY : uepc_pkg::RESP_SLVERR;
      unique case (rd_off)
        uepc_pkg::OFF_LAST_ENDPOINT:  next_rdata = {27'h0, ep_valid, last_ep}; // [RULE_01] [RULE_02]
        uepc_pkg::OFF_SPECIAL_MASK:   next_rdata = {16'h0, special_mask};
        uepc_pkg::OFF_OTG_FLAG_MASK:  next_rdata = otg_flag_mask;
        uepc_pkg::OFF_POWER_SIGNAL:   next_rdata = {23'h0, power_signalling};
        uepc_pkg::OFF_PHY_CONTROL:    next_rdata = phy_control & uepc_pkg::WMASK_PHY; // [RULE_12]
        uepc_pkg::OFF_DEVICE_ADDRESS: next_rdata = {25'h0, device_address};
        uepc_pkg::OFF_IRQ_STATUS:     next_rdata = {29'h0, irq_status};
        uepc_pkg::OFF_IRQ_MASK:       next_rdata = {29'h0, irq_mask};
        default:                      next_rdata = uepc_pkg::RST_ZERO;
      endcase
    end
    else if (rvalid && s_axi_rready)
      next_rvalid = 1'b0;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      last_ep          <= 4'h0;
      ep_valid         <= 1'b0;
      special_mask     <= 16'h0000;
      otg_flag_mask    <= uepc_pkg::RST_ZERO;
      power_signalling <= 9'h000;
      phy_control      <= uepc_pkg::RST_ZERO;
      device_address   <= 7'h00;
      irq_status       <= 3'h0;
      irq_mask         <= 3'h0;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= 2'b00;
      rvalid  <= 1'b0;
      rresp   <= 2'b00;
      rdata   <= 32'h0000_0000;
      ls_cand  <= 2'b01;
      ls_count <= 16'h0000;
      ls_filt  <= 2'b01;
      resume_q <= 1'b0;
      rx_endpoint       <= '0;
      rx_endpoint_valid <= 1'b0;
      irq               <= 1'b0;
    end
    else
    begin
      last_ep          <= next_last_ep;
      ep_valid         <= next_ep_valid;
      special_mask     <= next_special_mask;
      otg_flag_mask    <= next_otg_flag_mask;
      power_signalling <= next_power_signalling;
      phy_control      <= next_phy_control;
      device_address   <= next_device_address;
      irq_status       <= next_irq_status;
      irq_mask         <= next_irq_mask;
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
      ls_cand  <= next_ls_cand;
      ls_count <= next_ls_count;
      ls_filt  <= next_ls_filt;
      resume_q <= next_resume_q;
      // Foreign tokens leave the receive port untouched
      if (tok_ok)
      begin
        rx_endpoint.endpoint <= token_in.endpoint;
        rx_endpoint.special  <= special_mask[token_in.endpoint]; // [RULE_03]
      end
      rx_endpoint_valid    <= tok_ok; // [RULE_10]
      irq                  <= |(next_irq_status & next_irq_mask);
    end
  end

  assign phy_config_pins =
    phy_control[uepc_pkg::PHY_CONF_MSB:uepc_pkg::PHY_CONF_LSB]; // [RULE_08]
  assign phy_port_a_pulldown_dis = phy_control[uepc_pkg::PHY_PD_DIS_BIT]; // [RULE_09]
  assign phy_port_b_pulldown_dis = phy_control[uepc_pkg::PHY_PD_DIS_BIT]; // [RULE_09]

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_ep_capture: assert property (tok_ok |=> last_ep == $past(token_in.endpoint) && ep_valid) // [RULE_01]
    else $error("Endpoint not captured");
  chk_ep_valid_hold: assert property (ep_valid |=> ep_valid) // [RULE_02]
    else $error("Endpoint valid dropped");
  chk_special_tag: assert property (tok_ok |=> rx_endpoint_valid
      && rx_endpoint.special == $past(special_mask[token_in.endpoint])) // [RULE_03]
    else $error("Special tag wrong");
  chk_se0_cause: assert property (resume_se0 |=> phy_control[13]) // [RULE_04]
    else $error("SE0 cause not set");
  chk_k_cause: assert property (resume_k |=> phy_control[12]) // [RULE_05]
    else $error("K cause not set");
  chk_filt_stable: assert property ($changed(ls_filt) |-> $past(phy_linestate) == ls_filt) // [RULE_11]
    else $error("Filter passed unstable state");
  chk_filt_zero: assert property (phy_control[11:8] == 4'h0 // [RULE_06]
      && phy_linestate != ls_filt |=> ls_filt == $past(phy_linestate))
    else $error("Filter delay wrong");
  chk_resume_gate: assert property (!phy_control[7] |=> !suspend_resume) // [RULE_07]
    else $error("Resume while polling");
  chk_addr_match: assert property (rx_endpoint_valid |-> $past(token_in.addr) == $past(device_address)) // [RULE_10]
    else $error("Foreign token passed");
  chk_reserved_rd: assert property (rvalid |-> rdata[31:19] == 13'h0000 || rresp != 2'b00
      || $past(rd_off) == uepc_pkg::OFF_OTG_FLAG_MASK) // [RULE_12]
    else $error("Reserved bits nonzero");
  chk_conf_pins: assert property (wr_fire && eff_wstrb[0] // [RULE_08]
      && wr_off == uepc_pkg::OFF_PHY_CONTROL |=> phy_config_pins == $past(eff_wdata[6:4]))
    else $error("Config pins mismatch");

  cov_write: cover property (wr_fire);
  cov_resume_k: cover property (resume_k);
  cov_resume_se0: cover property (resume_se0);
  cov_token: cover property (tok_ok);

endmodule : uepc_top
